// *** logic/core_regs.sv ***
// Programmer-visible core registers, context flag pairs and return stack
`timescale 1ns/1ps
module core_regs
	import core_regs_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Sequencer control
	input  wire logic                step,
	input  wire logic                fetch,
	input  wire pc_op_t              pc_op,
	input  wire logic [PC_WIDTH-1:0] target,
	input  wire logic [7:0]          rel_offset,
	input  wire logic [PC_WIDTH-1:0] vector,
	input  wire logic                pending_int,
	// ALU flag update
	input  wire flag_op_t            flag_op,
	input  wire logic [7:0]          alu_result,
	input  wire logic                alu_carry,
	input  wire logic                tested_bit,
	input  wire logic                rotate_msb,
	// Data-space access
	input  wire logic                data_wr,
	input  wire logic [7:0]          data_addr,
	input  wire logic [7:0]          data_wdata,
	input  wire logic                ptr_sel,
	// Program memory and data outputs
	output logic [PC_WIDTH-1:0]      instruction_address_counter,
	output logic [7:0]               data_rdata,
	output logic                     data_hit,
	output logic [7:0]               indirect_addr,
	output logic [7:0]               accumulator,
	// Flag and context state
	output logic                     carry_flag,
	output logic                     zero_flag,
	output context_t                 context_state,
	output logic [2:0]               stack_depth
);

	logic [7:0]          pointer_reg_first;
	logic [7:0]          pointer_reg_second;
	logic [7:0]          short_direct_reg_first;
	logic [7:0]          short_direct_reg_second;
	logic [PC_WIDTH-1:0] stack_level [STACK_DEPTH];
	logic [2:0]          depth;
	context_t            ctx_stack [STACK_DEPTH];
	logic                normal_carry_flag;
	logic                normal_zero_flag;
	logic                interrupt_carry_flag;
	logic                interrupt_zero_flag;
	logic                nonmaskable_carry_flag;
	logic                nonmaskable_zero_flag;
	logic                next_carry;
	logic                next_zero;
	logic                cur_carry;
	logic                cur_zero;
	logic                is_push;
	logic                is_pop;
	logic [PC_WIDTH-1:0] next_pc;
	logic [PC_WIDTH-1:0] rel_sum;
	context_t            next_ctx;

	// Signed offset added to counter by a local adder, not through the ALU
	function automatic logic [PC_WIDTH-1:0] rel_add(input logic [PC_WIDTH-1:0] pc,
			input logic [7:0] off);
		rel_add = pc + {{(PC_WIDTH-8){off[7]}}, off};
	endfunction

	function automatic logic [7:0] mapped_read(input logic [7:0] addr,
			input logic [7:0] x, input logic [7:0] y, input logic [7:0] v,
			input logic [7:0] w, input logic [7:0] a);
		unique case (addr)
			ADDR_POINTER_FIRST:       mapped_read = x;
			ADDR_POINTER_SECOND:      mapped_read = y;
			ADDR_SHORT_DIRECT_FIRST:  mapped_read = v;
			ADDR_SHORT_DIRECT_SECOND: mapped_read = w;
			ADDR_ACCUMULATOR:         mapped_read = a;
			default:                  mapped_read = DATA_RESET;
		endcase
	endfunction

	assign is_push = step && (pc_op == PC_CALL || pc_op == PC_INT || pc_op == PC_NMI);
	assign is_pop  = step && (pc_op == PC_RETURN || pc_op == PC_IRETURN);
	assign rel_sum = rel_add(instruction_address_counter, rel_offset);

	// Counter source select; bank switching is outside, counter stays 12 bits
	always_comb begin
		next_pc = instruction_address_counter;
		if (step) begin
			unique case (pc_op)
				PC_NEXT:     next_pc = fetch ? instruction_address_counter + 12'h001
				                             : instruction_address_counter;
				PC_JUMP,
				PC_CALL:     next_pc = target;
				PC_RELATIVE: next_pc = rel_sum;
				PC_INT,
				PC_NMI:      next_pc = vector;
				PC_RETURN,
				PC_IRETURN:  next_pc = (depth != DEPTH_ZERO) ? stack_level[0]
				                     : instruction_address_counter + 12'h001;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			instruction_address_counter <= RESET_VECTOR;
		end else begin
			instruction_address_counter <= next_pc;
		end
	end

	// Return stack: shift register of six levels, no pointer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_level[i] <= '0;
				ctx_stack[i]   <= CTX_NORMAL;
			end
			depth <= DEPTH_ZERO;
		end else if (is_push) begin
			for (int i = STACK_DEPTH - 1; i > 0; i--) begin
				stack_level[i] <= stack_level[i-1];
				ctx_stack[i]   <= ctx_stack[i-1];
			end
			stack_level[0] <= (pc_op == PC_CALL) ? instruction_address_counter + 12'h001
			                                     : instruction_address_counter;
			ctx_stack[0]   <= context_state;
			if (depth != DEPTH_FULL) begin
				depth <= depth + 3'h1;
			end
		end else if (is_pop && depth != DEPTH_ZERO) begin
			for (int i = 0; i < STACK_DEPTH - 1; i++) begin
				stack_level[i] <= stack_level[i+1];
				ctx_stack[i]   <= ctx_stack[i+1];
			end
			depth <= depth - 3'h1;
		end
	end

	// Context tracking
	always_comb begin
		next_ctx = context_state;
		if (step) begin
			if (pc_op == PC_NMI) begin
				next_ctx = CTX_NMI;
			end else if (pc_op == PC_INT) begin
				next_ctx = CTX_INTERRUPT;
			end else if (pc_op == PC_IRETURN) begin
				// Empty stack: leaving post-reset context goes to normal mode
				next_ctx = (depth != DEPTH_ZERO) ? ctx_stack[0] : CTX_NORMAL;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			context_state <= CTX_NMI;
		end else begin
			context_state <= next_ctx;
		end
	end

	// Active pair only; switching never clears a pair
	always_comb begin
		unique case (context_state)
			CTX_NORMAL:    begin cur_carry = normal_carry_flag;      cur_zero = normal_zero_flag;      end
			CTX_INTERRUPT: begin cur_carry = interrupt_carry_flag;   cur_zero = interrupt_zero_flag;   end
			default:       begin cur_carry = nonmaskable_carry_flag; cur_zero = nonmaskable_zero_flag; end
		endcase
		next_carry = cur_carry;
		next_zero  = cur_zero;
		unique case (flag_op)
			FLAG_ARITH:  begin
				next_carry = alu_carry;
				next_zero  = (alu_result == 8'h00);
			end
			FLAG_LOGIC:  next_zero  = (alu_result == 8'h00);
			FLAG_BITTST: next_carry = tested_bit;
			FLAG_ROTATE: begin
				next_carry = rotate_msb;
				next_zero  = (alu_result == 8'h00);
			end
			default:     ;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			normal_carry_flag      <= 1'b0;
			normal_zero_flag       <= 1'b0;
			interrupt_carry_flag   <= 1'b0;
			interrupt_zero_flag    <= 1'b0;
			nonmaskable_carry_flag <= 1'b0;
			nonmaskable_zero_flag  <= 1'b0;
		end else if (step) begin
			unique case (context_state)
				CTX_NORMAL: begin
					normal_carry_flag <= next_carry;
					normal_zero_flag  <= next_zero;
				end
				CTX_INTERRUPT: begin
					interrupt_carry_flag <= next_carry;
					interrupt_zero_flag  <= next_zero;
				end
				default: begin
					nonmaskable_carry_flag <= next_carry;
					nonmaskable_zero_flag  <= next_zero;
				end
			endcase
		end
	end

	// Data-space mapped registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pointer_reg_first       <= DATA_RESET;
			pointer_reg_second      <= DATA_RESET;
			short_direct_reg_first  <= DATA_RESET;
			short_direct_reg_second <= DATA_RESET;
			accumulator             <= DATA_RESET;
		end else if (data_wr) begin
			unique case (data_addr)
				ADDR_POINTER_FIRST:       pointer_reg_first       <= data_wdata;
				ADDR_POINTER_SECOND:      pointer_reg_second      <= data_wdata;
				ADDR_SHORT_DIRECT_FIRST:  short_direct_reg_first  <= data_wdata;
				ADDR_SHORT_DIRECT_SECOND: short_direct_reg_second <= data_wdata;
				ADDR_ACCUMULATOR:         accumulator             <= data_wdata;
				default:                  ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_rdata    <= DATA_RESET;
			data_hit      <= 1'b0;
			indirect_addr <= DATA_RESET;
			carry_flag    <= 1'b0;
			zero_flag     <= 1'b0;
			stack_depth   <= DEPTH_ZERO;
		end else begin
			data_rdata <= mapped_read(data_addr, pointer_reg_first, pointer_reg_second,
				short_direct_reg_first, short_direct_reg_second, accumulator);
			data_hit <= (data_addr[7:2] == ADDR_POINTER_FIRST[7:2])
				|| (data_addr == ADDR_ACCUMULATOR);
			indirect_addr <= ptr_sel ? pointer_reg_second : pointer_reg_first;
			carry_flag    <= cur_carry;
			zero_flag     <= cur_zero;
			stack_depth   <= depth;
		end
	end

endmodule

// *** logic/core_regs_pkg.sv ***
// Constants and types for the core register, flag and return stack block
// Functional notes
// - Accumulator readable/writable at data address FFh
// - Pointer registers mapped at 80h and 81h
// - Short-direct registers mapped at 82h and 83h
// - Indirect mode uses selected pointer as address
// - Instruction address counter is twelve bits wide
// - Wider program space uses bank register, not counter
// - Counter sources: jump, relative, vector, pop, increment
// - Counter increments after each fetch
// - Relative branch sum formed in ALU, written back; here formed locally by rel_add and loaded directly
// - Three flag pairs; only active context's pair used
// - Interrupt entry switches pair; return restores previous
// - Flags kept across switches; only own context access
// - Carry: arithmetic carry, bit test copy, rotate left
// - Zero set when result equals zero
// - Reset starts in non-maskable context
// - Six twelve-bit stack levels, no stack pointer
// - Push shifts levels deeper, sixth level lost
// - Pop loads counter, deeper levels move up
// - Over six nestings the oldest address is lost
// - Return on empty stack continues sequentially
// - Reset clears stack, loads reset vector 0FFEh
// - Return from post-reset context enters normal context
package core_regs_pkg;
	localparam logic [7:0]  ADDR_POINTER_FIRST      = 8'h80;
	localparam logic [7:0]  ADDR_POINTER_SECOND     = 8'h81;
	localparam logic [7:0]  ADDR_SHORT_DIRECT_FIRST = 8'h82;
	localparam logic [7:0]  ADDR_SHORT_DIRECT_SECOND = 8'h83;
	localparam logic [7:0]  ADDR_ACCUMULATOR        = 8'hFF;
	localparam int          PC_WIDTH                = 12;
	localparam int          STACK_DEPTH             = 6;
	localparam logic [11:0] RESET_VECTOR            = 12'hFFE;
	localparam logic [7:0]  DATA_RESET              = 8'h00;
	localparam logic [2:0]  DEPTH_ZERO              = 3'h0;
	localparam logic [2:0]  DEPTH_FULL              = 3'h6;

	typedef enum logic [1:0] {
		CTX_NORMAL    = 2'b00,
		CTX_INTERRUPT = 2'b01,
		CTX_NMI       = 2'b11
	} context_t;

	typedef enum logic [2:0] {
		PC_NEXT     = 3'h0,
		PC_JUMP     = 3'h1,
		PC_CALL     = 3'h2,
		PC_RELATIVE = 3'h3,
		PC_INT      = 3'h4,
		PC_NMI      = 3'h5,
		PC_RETURN   = 3'h6,
		PC_IRETURN  = 3'h7
	} pc_op_t;

	typedef enum logic [2:0] {
		FLAG_NONE   = 3'h0,
		FLAG_ARITH  = 3'h1,
		FLAG_LOGIC  = 3'h2,
		FLAG_BITTST = 3'h3,
		FLAG_ROTATE = 3'h4
	} flag_op_t;
endpackage

// *** tb/core_regs_bench.sv ***
// Self-checking bench for the core register, flag and return stack block
`timescale 1ns/1ps
module core_regs_bench
	import core_regs_pkg::*;
;
	logic clk, rst_n, step, fetch, pending_int, alu_carry, tested_bit, rotate_msb;
	logic data_wr, ptr_sel, data_hit, carry_flag, zero_flag;
	pc_op_t pc_op;
	flag_op_t flag_op;
	logic [11:0] target, vector, instruction_address_counter;
	logic [7:0] rel_offset, alu_result, data_addr, data_wdata, data_rdata;
	logic [7:0] indirect_addr, accumulator, opcode;
	context_t context_state;
	logic [2:0] stack_depth;
	int mismatches, n_tests;
	wire [11:0] pc = instruction_address_counter;
	core_regs DUT (.clk, .rst_n, .step, .fetch, .pc_op, .target, .rel_offset, .vector,
		.pending_int, .flag_op, .alu_result, .alu_carry, .tested_bit, .rotate_msb,
		.data_wr, .data_addr, .data_wdata, .ptr_sel, .instruction_address_counter,
		.data_rdata, .data_hit, .indirect_addr, .accumulator, .carry_flag, .zero_flag,
		.context_state, .stack_depth);
	prog_mem_model pmem (.fetch_addr(pc), .opcode(opcode));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// One step pulse, then wait until the lagged outputs settle
	task automatic op(input pc_op_t p, input flag_op_t f = FLAG_NONE);
		@(negedge clk);
		step = 1'b1;
		pc_op = p;
		flag_op = f;
		@(negedge clk);
		step = 1'b0;
		@(negedge clk);
	endtask
	task automatic fl(input logic c, input logic z);
		chk("carry_flag", c, carry_flag);
		chk("zero_flag", z, zero_flag);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		data_wr = 1'b1;
		data_addr = a;
		data_wdata = d;
		@(negedge clk);
		data_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
		@(negedge clk);
		data_addr = a;
		@(negedge clk);
		chk("data_rdata", e, data_rdata);
		chk("data_hit", h, data_hit);
	endtask
	task automatic t_reset();
		rst_n = 1'b0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("pc reset", 12'hFFE, pc);
		chk("ctx reset", CTX_NMI, context_state);
		chk("depth reset", 3'h0, stack_depth);
	endtask
	task automatic t_regs();
		logic [7:0] adr [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
		for (int i = 0; i < 5; i++) wr(adr[i], 8'h3C + 8'(i));
		for (int i = 0; i < 5; i++) rd(adr[i], 8'h3C + 8'(i), 1'b1);
		wr(8'h84, 8'hA5);
		rd(8'h84, 8'h00, 1'b0);
		chk("accumulator", 8'h40, accumulator);
		ptr_sel = 1'b0;
		@(negedge clk);
		chk("indirect first", 8'h3C, indirect_addr);
		ptr_sel = 1'b1;
		@(negedge clk);
		chk("indirect second", 8'h3D, indirect_addr);
	endtask
	task automatic t_pc();
		target = 12'hFFF;
		op(PC_JUMP);
		chk("pc jump", 12'hFFF, pc);
		op(PC_NEXT);
		chk("pc wrap", 12'h000, pc);
		fetch = 1'b0;
		op(PC_NEXT);
		chk("pc hold", 12'h000, pc);
		fetch = 1'b1;
		rel_offset = 8'h05;
		op(PC_RELATIVE);
		chk("pc fwd", 12'h005, pc);
		rel_offset = 8'hF9;
		op(PC_RELATIVE);
		chk("pc back", 12'hFFE, pc);
	endtask
	task automatic t_stack();
		op(PC_IRETURN);
		chk("ctx exit", CTX_NORMAL, context_state);
		chk("pc iret empty", 12'hFFF, pc);
		op(PC_RETURN);
		chk("pc ret empty", 12'h000, pc);
		for (int i = 0; i < 7; i++) begin
			target = 12'h100 + 12'(i);
			op(PC_CALL);
		end
		chk("depth full", 3'h6, stack_depth);
		for (int i = 0; i < 6; i++) begin
			op(PC_RETURN);
			chk("pc pop", 12'h106 - 12'(i), pc);
		end
		chk("depth drained", 3'h0, stack_depth);
	endtask
	task automatic t_flags();
		alu_result = 8'h00;
		op(PC_NEXT, FLAG_LOGIC);
		fl(1'b0, 1'b1);
		alu_result = 8'h05;
		alu_carry = 1'b1;
		op(PC_NEXT, FLAG_ARITH);
		fl(1'b1, 1'b0);
		op(PC_INT);
		chk("ctx int", CTX_INTERRUPT, context_state);
		fl(1'b0, 1'b0);
		alu_result = 8'h00;
		alu_carry = 1'b0;
		op(PC_NEXT, FLAG_ARITH);
		vector = 12'h3F8;
		op(PC_NMI);
		chk("ctx nmi", CTX_NMI, context_state);
		tested_bit = 1'b1;
		op(PC_NEXT, FLAG_BITTST);
		fl(1'b1, 1'b0);
		op(PC_IRETURN);
		chk("pc iret", 12'h3F1, pc);
		fl(1'b0, 1'b1);
		op(PC_IRETURN);
		chk("pc iret normal", 12'h103, pc);
		fl(1'b1, 1'b0);
		// Result still zero from the last operation, so rotate also raises zero
		op(PC_NEXT, FLAG_ROTATE);
		fl(1'b0, 1'b1);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		{step, pending_int, alu_carry, tested_bit, rotate_msb, data_wr, ptr_sel} = '0;
		{target, rel_offset, alu_result, data_addr, data_wdata} = '0;
		vector = 12'h3F0;
		pc_op = PC_NEXT;
		flag_op = FLAG_NONE;
		fetch = 1'b1;
		t_reset();
		t_regs();
		t_pc();
		t_stack();
		t_flags();
		t_reset();
		tally_and_finish();
	end
	initial begin
		#200000;
		mismatches++;
		tally_and_finish();
	end
endmodule

// *** tb/core_regs_props.sv ***
// Checker for the core register, flag and return stack block
`timescale 1ns/1ps
module core_regs_props
	import core_regs_pkg::*;
(
	// Clock, reset and controls
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        step,
	input wire logic        fetch,
	input wire pc_op_t      pc_op,
	input wire flag_op_t    flag_op,
	// Operands
	input wire logic [11:0] target,
	input wire logic [7:0]  rel_offset,
	input wire logic [11:0] vector,
	input wire logic [7:0]  alu_result,
	input wire logic        tested_bit,
	input wire logic        data_wr,
	input wire logic [7:0]  data_addr,
	input wire logic [7:0]  data_wdata,
	// Observed state
	input wire logic [11:0] instruction_address_counter,
	input wire logic        data_hit,
	input wire logic [7:0]  accumulator,
	input wire logic        carry_flag,
	input wire logic        zero_flag,
	input wire context_t    context_state,
	input wire logic [2:0]  stack_depth
);
	wire [11:0] pc = instruction_address_counter;
	wire mapped = data_addr inside {[8'h80:8'h83], 8'hFF};
	wire nx = step && pc_op == PC_NEXT;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_acc_write: assert property (data_wr && data_addr == 8'hFF
		|=> accumulator == $past(data_wdata)) else $error("accumulator write lost");
	chk_map_hit: assert property ($past(rst_n) |-> data_hit == $past(mapped))
		else $error("data hit wrong");
	chk_pc_next: assert property (nx && fetch |=> pc == $past(pc) + 12'h001)
		else $error("counter did not advance");
	chk_pc_load: assert property (step && pc_op inside {PC_JUMP, PC_CALL}
		|=> pc == $past(target)) else $error("jump target not loaded");
	chk_rel_sum: assert property (step && pc_op == PC_RELATIVE |=> pc == $past(pc)
		+ {{4{$past(rel_offset[7])}}, $past(rel_offset)}) else $error("relative sum wrong");
	chk_int_entry: assert property (step && pc_op == PC_INT |=> pc == $past(vector)
		&& context_state == CTX_INTERRUPT) else $error("interrupt entry wrong");
	chk_empty_pop: assert property (!$past(step) && step && pc_op == PC_RETURN
		&& stack_depth == 3'h0 |=> pc == $past(pc) + 12'h001) else $error("empty pop wrong");
	chk_zero_result: assert property (nx && flag_op == FLAG_LOGIC |=> ##1
		zero_flag == ($past(alu_result, 2) == 8'h00)) else $error("zero flag wrong");
	chk_bit_copy: assert property (nx && flag_op == FLAG_BITTST |=> ##1
		carry_flag == $past(tested_bit, 2)) else $error("bit test carry wrong");
	chk_depth_cap: assert property (stack_depth <= 3'h6)
		else $error("stack deeper than six");
	chk_reset_exit: assert property (disable iff (1'b0) rst_n && !$past(rst_n)
		|-> pc == RESET_VECTOR && context_state == CTX_NMI && stack_depth == 3'h0)
		else $error("reset state wrong");
	cover property (step && pc_op == PC_CALL && stack_depth == 3'h6);
	cover property (step && pc_op == PC_IRETURN && context_state == CTX_NMI);
	cover property (step && pc_op == PC_RETURN && stack_depth == 3'h0);
endmodule
bind core_regs core_regs_props u_props (.clk, .rst_n, .step, .fetch, .pc_op, .flag_op,
	.target, .rel_offset, .vector, .alu_result, .tested_bit, .data_wr, .data_addr,
	.data_wdata, .instruction_address_counter, .data_hit, .accumulator, .carry_flag,
	.zero_flag, .context_state, .stack_depth);

// *** tb/prog_mem_model.sv ***
// Program memory model answering fetches from the address counter
`timescale 1ns/1ps
module prog_mem_model (
	// Fetch address and opcode
	input  wire logic [11:0] fetch_addr,
	output logic      [7:0]  opcode
);
	// Software saves data registers itself; only addresses and contexts stack
	assign opcode = fetch_addr[7:0] ^ fetch_addr[11:4];
endmodule
